// File: rtl/dpsc_decoder.sv
// serial command decoder of a dual 256-tap digital potentiometer
// assumes sclk idles low outside frames, cs_n high ends a frame
//
// How it works
// [R1] address byte 010100 plus the pin address, then wiper write 1010 00 pp and one data byte.
// [R2] stored read 1011 ss pp shifts the stored byte out msb first.
// [R3] stored write 1100 ss pp takes one data byte into the chosen stored slot.
// [R4] a frame that changed a stored slot starts programming when chip select rises.
// [R5] global load 0001 ss 00 copies slot ss of both pots into their wipers.
// [R6] global save 1000 ss 00 copies both wipers into slot ss and programs.
// [R7] single save 1110 ss pp copies one wiper into one slot and programs.
// [R8] single load 1101 ss pp copies one slot into that wiper.
// [R9] step command 0010 00 pp then takes one step bit per clock until chip select rises.
// [R10] a high step bit moves the wiper up one tap, a low one moves it down.
// [R11] wiper read 1001 00 pp shifts the wiper byte out.
// [R12] status read 0101 0001 returns the write in progress flag in the last bit.
// [R13] programming ends within 5 ms and the flag stays set until then.
// [R14] a wrong address or unknown code leaves the output undriven and nothing changed.
`timescale 1ns/100ps
`include "dpsc_params.svh"
module dpsc_decoder #(
    parameter int unsigned NV_CYCLES = `DPSC_NV_WRITE_CYCLES
) (
    // core clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // serial link
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       si,
    output logic            so,
    output logic            so_oe,
    // address strap pins
    input  wire logic       addr_select_pin_hi,
    input  wire logic       addr_select_pin_lo,
    // wiper positions toward the resistor arrays
    output logic [7:0]      wiper_setting_register_0,
    output logic [7:0]      wiper_setting_register_1,
    // status
    output logic            write_in_progress_flag
);
    // ==========================================================
    // link domain: frame decode on sclk
    // ==========================================================
    dpsc_pkg::dpsc_phase_type phase;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [3:0] op;
    logic [1:0] slot;
    logic [1:0] pot;
    logic       frame_rst;
    logic       nv_req_tgl;
    logic [7:0] wiper [0:1];
    logic [7:0] store [0:7];
    logic [7:0] rd_byte;
    logic       rd_active;
    logic       nv_pending;
    logic       wip_meta;
    logic       wip_link;
    logic       wip_core;
    logic [1:0] strap_meta;
    logic [1:0] strap_sync;

    // frame state cleared asynchronously by chip select high, the link clock stops
    assign frame_rst = cs_n;

    wire [7:0] next_shift   = {shift[6:0], si};
    wire       byte_end     = (bit_cnt == `DPSC_BIT_LAST);
    wire       addr_ok      = (next_shift[7:2] == `DPSC_ADDR_FIXED) &&
                              (next_shift[1:0] == strap_sync);
    wire [3:0] n_op         = next_shift[7:4];
    wire [1:0] n_slot       = next_shift[3:2];
    wire [1:0] n_pot        = next_shift[1:0];
    wire       low_zero     = (n_slot == 2'h0);
    wire       glob_ok      = (n_pot == 2'h0);
    wire       op_rd_wiper  = (n_op == `DPSC_OP_WIPER_RD) && low_zero;   // R11
    wire       op_rd_store  = (n_op == `DPSC_OP_STORE_RD);               // R2
    wire       op_status    = (n_op == `DPSC_OP_STATUS) &&
                              (next_shift[3:0] == `DPSC_STATUS_LOW);   // R12
    wire       op_wr_wiper  = (n_op == `DPSC_OP_WIPER_WR) && low_zero;   // R1
    wire       op_wr_store  = (n_op == `DPSC_OP_STORE_WR);               // R3
    wire       op_step      = (n_op == `DPSC_OP_STEP) && low_zero;       // R9
    wire       op_load_one  = (n_op == `DPSC_OP_LOAD_ONE);
    wire       op_save_one  = (n_op == `DPSC_OP_SAVE_ONE);
    wire       op_load_all  = (n_op == `DPSC_OP_LOAD_ALL) && glob_ok;
    wire       op_save_all  = (n_op == `DPSC_OP_SAVE_ALL) && glob_ok;
    wire       op_read      = op_rd_wiper | op_rd_store | op_status;
    wire       op_data      = op_read | op_wr_wiper | op_wr_store;
    wire       op_twobyte   = op_load_one | op_save_one | op_load_all | op_save_all;
    wire       op_known     = op_data | op_step | op_twobyte;        // R14
    wire       pot_ok       = (n_pot[1] == 1'b0);                    // only pots 0 and 1 exist
    wire [7:0] status_byte  = {7'h00, wip_link};                     // R12

    // stored slot index from pot and slot
    function automatic logic [2:0] slot_index(input logic p, input logic [1:0] s);
        slot_index = {p, s};
    endfunction

    // one tap step with clamping at the ends
    function automatic logic [7:0] tap_step(input logic [7:0] w, input logic up);
        if (up) begin
            tap_step = (w == `DPSC_TAP_MAX) ? w : w + 8'h01;
        end else begin
            tap_step = (w == `DPSC_TAP_MIN) ? w : w - 8'h01;
        end
    endfunction

    // write in progress and the strap pins seen from the link side, two flops each
    always_ff @(posedge sclk) begin
        wip_meta   <= wip_core;
        wip_link   <= wip_meta;
        strap_meta <= {addr_select_pin_hi, addr_select_pin_lo};
        strap_sync <= strap_meta;
    end

    // phase, shift register and bit counter
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            phase   <= dpsc_pkg::DPSC_ADDR;
            shift   <= 8'h00;
            bit_cnt <= 3'h0;
            op      <= 4'h0;
            slot    <= 2'h0;
            pot     <= 2'h0;
        end else begin
            shift   <= next_shift;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_end) begin
                case (phase)
                    dpsc_pkg::DPSC_ADDR: begin
                        phase <= addr_ok ? dpsc_pkg::DPSC_INSTR : dpsc_pkg::DPSC_SKIP; // R1 R14
                    end
                    dpsc_pkg::DPSC_INSTR: begin
                        op   <= n_op;
                        slot <= n_slot;
                        pot  <= n_pot;
                        if (!op_known || (!pot_ok && !(op_load_all || op_save_all
                                                       || op_status)))
                            phase <= dpsc_pkg::DPSC_SKIP;                     // R14
                        else if (op_step)
                            phase <= dpsc_pkg::DPSC_STEP;                     // R9
                        else if (op_data)
                            phase <= dpsc_pkg::DPSC_DATA;
                        else
                            phase <= dpsc_pkg::DPSC_DONE;
                    end
                    dpsc_pkg::DPSC_DATA: phase <= dpsc_pkg::DPSC_DONE;
                    dpsc_pkg::DPSC_STEP: phase <= dpsc_pkg::DPSC_STEP;
                    dpsc_pkg::DPSC_DONE: phase <= dpsc_pkg::DPSC_DONE;
                    default:             phase <= dpsc_pkg::DPSC_SKIP;
                endcase
            end
        end
    end

    // register array updates; arrays are kept on the link clock so no word crosses
    // limitation: no power-up recall, wipers and slots start from the reset value
    wire instr_end = byte_end && (phase == dpsc_pkg::DPSC_INSTR) && pot_ok;
    wire data_end  = byte_end && (phase == dpsc_pkg::DPSC_DATA);
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            wiper[0] <= `DPSC_WIPER_RESET;
            wiper[1] <= `DPSC_WIPER_RESET;
            for (int i = 0; i < 8; i++) begin
                store[i] <= `DPSC_WIPER_RESET;
            end
        end else if (!cs_n) begin
            if (data_end && op == `DPSC_OP_WIPER_WR)
                wiper[pot[0]] <= next_shift;                                  // R1
            if (data_end && op == `DPSC_OP_STORE_WR)
                store[slot_index(pot[0], slot)] <= next_shift;                // R3
            if (phase == dpsc_pkg::DPSC_STEP)
                wiper[pot[0]] <= tap_step(wiper[pot[0]], si);                 // R9 R10
            if (byte_end && phase == dpsc_pkg::DPSC_INSTR) begin
                if (op_load_one && pot_ok)
                    wiper[n_pot[0]] <= store[slot_index(n_pot[0], n_slot)];    // R8
                if (op_save_one && pot_ok)
                    store[slot_index(n_pot[0], n_slot)] <= wiper[n_pot[0]];    // R7
                if (op_load_all) begin
                    wiper[0] <= store[slot_index(1'b0, n_slot)];               // R5
                    wiper[1] <= store[slot_index(1'b1, n_slot)];
                end
                if (op_save_all) begin
                    store[slot_index(1'b0, n_slot)] <= wiper[0];               // R6
                    store[slot_index(1'b1, n_slot)] <= wiper[1];
                end
            end
        end
    end

    // a stored change marks the frame; kept past chip select rise so the toggle
    // flop sees a settled level, cleared on the first clock of the next frame
    wire frame_first = (phase == dpsc_pkg::DPSC_ADDR) && (bit_cnt == 3'h0);
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            nv_pending <= 1'b0;
        end else if ((data_end && op == `DPSC_OP_STORE_WR) ||
                     (instr_end && (op_save_one || op_save_all))) begin
            nv_pending <= 1'b1;                                               // R4
        end else if (frame_first) begin
            nv_pending <= 1'b0;
        end
    end

    // the frame's own end carries the event: toggle on cs_n rise
    always_ff @(posedge cs_n or posedge srst) begin
        if (srst) begin
            nv_req_tgl <= 1'b0;
        end else if (nv_pending) begin
            nv_req_tgl <= ~nv_req_tgl;                                        // R4
        end
    end

    // read byte loaded at the end of the instruction byte
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            rd_byte   <= 8'h00;
            rd_active <= 1'b0;
        end else if (byte_end && phase == dpsc_pkg::DPSC_INSTR) begin
            rd_active <= op_read && (pot_ok || op_status);
            rd_byte   <= op_status   ? status_byte :                          // R12
                         op_rd_store ? store[slot_index(n_pot[0], n_slot)] :  // R2
                                       wiper[n_pot[0]];                       // R11
        end else if (phase == dpsc_pkg::DPSC_DATA) begin
            rd_byte <= {rd_byte[6:0], 1'b0};
        end else if (byte_end) begin
            rd_active <= 1'b0;
        end
    end

    // output changes on the falling edge, msb first
    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so    <= rd_byte[7];
            so_oe <= rd_active && (phase == dpsc_pkg::DPSC_DATA);             // R14
        end
    end

    assign wiper_setting_register_0 = wiper[0];
    assign wiper_setting_register_1 = wiper[1];

    // ==========================================================
    // core domain: programming cycle timing
    // ==========================================================
    logic req_s1;
    logic req_s2;
    logic req_s3;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= nv_req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end
    wire nv_start = req_s2 ^ req_s3;                                          // R4

    dpsc_nv_timer #(.CYCLES(NV_CYCLES)) u_timer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (nv_start),
        .busy    (wip_core)
    );
    assign write_in_progress_flag = wip_core;                                 // R13

    // a programming start raises the flag on the next clock
    property p_start_sets_wip;
        @(posedge ref_clk) disable iff (srst)
        nv_start |=> write_in_progress_flag;
    endproperty
    a_start_sets_wip: assert property (p_start_sets_wip) else $error("no wip"); // R4
    // the flag never rises without a start
    property p_wip_cause;
        @(posedge ref_clk) disable iff (srst)
        $rose(write_in_progress_flag) |-> $past(nv_start);
    endproperty
    a_wip_cause: assert property (p_wip_cause) else $error("wip without start"); // R13
    // a refused frame never drives the output
    property p_so_quiet;
        @(posedge sclk) disable iff (cs_n)
        (phase == dpsc_pkg::DPSC_SKIP) |-> !so_oe;
    endproperty
    a_so_quiet: assert property (p_so_quiet) else $error("so driven in skip"); // R14
    // a high step bit moves wiper 0 up one tap unless it sits at the top
    property p_step_up;
        @(posedge sclk) disable iff (cs_n || srst)
        (phase == dpsc_pkg::DPSC_STEP) && si && !pot[0] &&
        (wiper_setting_register_0 != `DPSC_TAP_MAX) |=>
        (wiper_setting_register_0 == $past(wiper_setting_register_0) + 8'h01);
    endproperty
    a_step_up: assert property (p_step_up) else $error("step up missed"); // R10
endmodule : dpsc_decoder

// File: pkg/dpsc_params.svh
// constants for the dual pot serial command decoder
// assumes inclusion by the design files, the decoder and the timer
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
`define DPSC_ADDR_FIXED      6'h14
`define DPSC_OP_WIPER_RD     4'h9
`define DPSC_OP_WIPER_WR     4'hA
`define DPSC_OP_STORE_RD     4'hB
`define DPSC_OP_STORE_WR     4'hC
`define DPSC_OP_LOAD_ONE     4'hD
`define DPSC_OP_SAVE_ONE     4'hE
`define DPSC_OP_LOAD_ALL     4'h1
`define DPSC_OP_SAVE_ALL     4'h8
`define DPSC_OP_STEP         4'h2
`define DPSC_OP_STATUS       4'h5
`define DPSC_STATUS_LOW      4'h1
`define DPSC_BIT_LAST        3'h7
`define DPSC_TAP_MAX         8'hFF
`define DPSC_TAP_MIN         8'h00
`define DPSC_WIPER_RESET     8'h00
`define DPSC_CLK_HZ          20000000
`define DPSC_NV_WRITE_US     5000
`define DPSC_NV_WRITE_CYCLES ((`DPSC_CLK_HZ / 1000000) * `DPSC_NV_WRITE_US)
`endif

// File: pkg/dpsc_pkg.sv
// types for the dual pot serial command decoder
// assumes dpsc_params.svh for the numeric constants
package dpsc_pkg;
    // frame phases on the serial clock, gray along the usual path
    typedef enum logic [2:0] {
        DPSC_ADDR  = 3'h0,
        DPSC_INSTR = 3'h1,
        DPSC_DATA  = 3'h3,
        DPSC_STEP  = 3'h5,
        DPSC_DONE  = 3'h2,
        DPSC_SKIP  = 3'h4
    } dpsc_phase_type;
endpackage : dpsc_pkg

// File: rtl/dpsc_nv_timer.sv
// programming cycle timer for the stored setting array
// assumes start pulse and reset on ref_clk
`timescale 1ns/100ps
`include "dpsc_params.svh"
module dpsc_nv_timer #(
    parameter int unsigned CYCLES = `DPSC_NV_WRITE_CYCLES
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // control
    input  wire logic start,
    output logic      busy
);
    logic [16:0] count;
    // reload on start, count down while busy
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= 17'h00000;
            busy  <= 1'b0;
        end else if (start) begin
            count <= 17'(CYCLES - 1);
            busy  <= 1'b1;
        end else if (busy) begin
            count <= count - 17'h00001;
            if (count == 17'h00000) begin
                busy <= 1'b0;
            end
        end
    end
    // a start must leave the flag up for at least the next 8 clocks
    property p_busy_holds;
        @(posedge ref_clk) disable iff (srst)
        start |=> busy [*8];
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early"); // R13
    // the flag drops on the clock after the count runs out
    property p_busy_ends;
        @(posedge ref_clk) disable iff (srst)
        busy && (count == 17'h00000) && !start |=> !busy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy overran"); // R13
endmodule : dpsc_nv_timer

// File: test/dpsc_host_model.sv
// serial host model that frames commands into the decoder
// assumes the bench calls frame() one at a time and nothing else drives the link
`timescale 1ns/100ps
module dpsc_host_model (
    // link toward the decoder
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    // read data back from the decoder
    input  wire logic so,
    input  wire logic so_oe
);
    // ==========================================================
    // idle state: clock stands low, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // ==========================================================
    // one frame, msb first; the read byte is caught before rising edges 17..24
    task automatic frame(input logic [23:0] bits, input int n, output logic [7:0] rd,
                         output logic oe_all, output logic oe_any);
        int i;
        rd     = 8'h00;
        oe_all = 1'b1;
        oe_any = 1'b0;
        cs_n   = 1'b0;
        for (i = 0; i < n; i++) begin
            si = bits[23 - i];
            #40;
            if (i >= 16) begin
                rd     = {rd[6:0], so};
                oe_all = oe_all & so_oe;
            end
            oe_any = oe_any | so_oe;
            sclk   = 1'b1;
            #40;
            sclk   = 1'b0;
        end
        #40;
        cs_n = 1'b1;
        si   = ~si; // released line shows the inverse, never a held value
        #200;
    endtask : frame
endmodule : dpsc_host_model

// File: test/testbench.sv
// self-checking bench for the serial command decoder
// assumes the host model drives the link; the programming count is shortened
`timescale 1ns/100ps
module testbench;
    localparam int NV = 60; // short programming count keeps the run brief
    typedef struct {
        logic [23:0] bits;
        int          n;
        logic [7:0]  w0;
        logic [7:0]  w1;
        logic [7:0]  rd;
        logic        rdk;
        logic        nv;
    } dpsc_row_type;

    // ==========================================================
    // signals
    logic       ref_clk, srst, sclk, cs_n, si, so, so_oe, a_hi, a_lo, flag, oa, on;
    logic [7:0] w0, w1, rd;
    int         fail_count, n_checks, r;
    int         hi_cnt   = 0;
    int         last_len = 0;

    // ordinary cases: frame, bit count, wipers after, read byte, read?, programs?
    dpsc_row_type rows [21] = '{
        '{24'h52A0A5, 24, 8'hA5, 8'h00, 8'h00, 1'b0, 1'b0},
        '{24'h52A13C, 24, 8'hA5, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h529100, 24, 8'hA5, 8'h3C, 8'h3C, 1'b1, 1'b0},
        '{24'h52C85A, 24, 8'hA5, 8'h3C, 8'h00, 1'b0, 1'b1},
        '{24'h52B800, 24, 8'hA5, 8'h3C, 8'h5A, 1'b1, 1'b0},
        '{24'h52D800, 16, 8'h5A, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h52ED00, 16, 8'h5A, 8'h3C, 8'h00, 1'b0, 1'b1},
        '{24'h52BD00, 24, 8'h5A, 8'h3C, 8'h3C, 1'b1, 1'b0},
        '{24'h528400, 16, 8'h5A, 8'h3C, 8'h00, 1'b0, 1'b1},
        '{24'h52A0FE, 24, 8'hFE, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h52A101, 24, 8'hFE, 8'h01, 8'h00, 1'b0, 1'b0},
        '{24'h5220C0, 19, 8'hFE, 8'h01, 8'h00, 1'b0, 1'b0},
        '{24'h522100, 18, 8'hFE, 8'h00, 8'h00, 1'b0, 1'b0},
        '{24'h521400, 16, 8'h5A, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h52A000, 24, 8'h00, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h53A077, 24, 8'h00, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h539100, 24, 8'h00, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h523077, 24, 8'h00, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h52A277, 24, 8'h00, 8'h3C, 8'h00, 1'b0, 1'b0},
        '{24'h525100, 24, 8'h00, 8'h3C, 8'h00, 1'b1, 1'b0},
        '{24'h52B400, 24, 8'h00, 8'h3C, 8'h5A, 1'b1, 1'b0}
    };

    // ==========================================================
    // clock and instances
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    dpsc_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    dpsc_decoder #(.NV_CYCLES(NV)) dut (
        .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe), .addr_select_pin_hi(a_hi), .addr_select_pin_lo(a_lo),
        .wiper_setting_register_0(w0), .wiper_setting_register_1(w1),
        .write_in_progress_flag(flag));

    // length of each busy stretch, sampled off the edge that moves the flag
    always @(negedge ref_clk) begin
        if (flag === 1'b1) hi_cnt <= hi_cnt + 1;
        else if (hi_cnt != 0) begin
            last_len <= hi_cnt;
            hi_cnt   <= 0;
        end
    end

    // ==========================================================
    // compare tasks and closing
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t byte got %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t bit got %b want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chki(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            fail_count++;
            $display("[FAIL] %0t count got %0d want %0d", $time, got, exp);
        end
    endtask : chki

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    // watch for programming after a frame; bounded waits only
    task automatic nv_check(input logic nv);
        int   k;
        logic seen;
        seen = 1'b0;
        for (k = 0; k < 30; k++) begin
            @(negedge ref_clk);
            seen = seen | (flag === 1'b1);
        end
        chk1(seen, nv);
        for (k = 0; k < NV + 40 && flag !== 1'b0; k++) @(negedge ref_clk);
        chk1(flag, 1'b0);
        @(negedge ref_clk);
        if (nv) chki(last_len, NV);
    endtask : nv_check

    // ==========================================================
    // main sequence
    initial begin
        fail_count = 0;
        n_checks   = 0;
        srst       = 1'b1;
        a_hi       = 1'b1;
        a_lo       = 1'b0;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        chk8(w0, 8'h00);
        chk8(w1, 8'h00);
        chk1(flag, 1'b0);
        chk1(so_oe, 1'b0);
        for (r = 0; r < 21; r++) begin
            @(negedge ref_clk);
            host.frame(rows[r].bits, rows[r].n, rd, oa, on);
            chk8(w0, rows[r].w0);
            chk8(w1, rows[r].w1);
            if (rows[r].rdk) begin
                chk8(rd, rows[r].rd);
                chk1(oa, 1'b1);
            end
            else chk1(on, 1'b0);
            nv_check(rows[r].nv);
        end
        // status read while a stored write is still programming
        @(negedge ref_clk);
        host.frame(24'h52C199, 24, rd, oa, on);
        host.frame(24'h525100, 24, rd, oa, on);
        chk8(rd, 8'h01);
        nv_check(1'b1);
        host.frame(24'h52B100, 24, rd, oa, on);
        chk8(rd, 8'h99);
        // reset in mid-run clears wipers, slots and the flag
        host.frame(24'h52A1C3, 24, rd, oa, on);
        chk8(w1, 8'hC3);
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        chk8(w1, 8'h00);
        chk1(flag, 1'b0);
        host.frame(24'h52B100, 24, rd, oa, on);
        chk8(rd, 8'h00);
        final_report();
    end

    // hang guard, well past the expected run length
    initial begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule : testbench
